//--- hdl/spmc_top.sv
// Power mode controller of the five-port switch
// Overview of operation
// - Holding the power-down pin low powers the whole chip down.
// - Releasing the power-down pin runs an internal reset before operation resumes.
// - Mode field 00 is normal, 01 energy detect, 10 soft power down, 11 power saving.
// - Bit 3 of a port's control 13 register powers down only that port's PHY.
// - After power-up or reset the mode field is 00, normal operation.
// - Normal mode keeps clocks, PHYs and MACs on and the host port accepting accesses.
// - From normal mode the host may write any other mode and the chip enters it.
// - Energy detect mode sleeps once no cable energy is seen for longer than go-sleep.
// - In the low power state only the receiver energy detector and the line pulse stay on.
// - Cable energy in the low power state returns the chip to normal power.
// - Energy detect mode emits a 120 ns pulse once per second on the line.
// - Soft power down stops the clocks and turns off every PHY and MAC.
// - Any host access in soft power down wakes to normal mode through an internal reset.
// - Power saving keeps the transmitter on and turns off only the unused receiver.
`timescale 1ns/1ns
`include "spmc_regs.svh"

module spmc_top
   import spmc_pkg::*;
#(
   parameter int unsigned PULSE_PER_CYC  = `SPMC_PULSE_PER_CYC,
   parameter int unsigned SLEEP_UNIT_CYC = `SPMC_SLEEP_UNIT_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       chip_power_down_input_n,
   input  wire logic [4:0] cable_energy,
   input  wire logic [4:0] an_enable,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            chip_powered_down,
   output logic            int_reset,
   output logic            pll_clk_en,
   output logic            mac_power_on,
   output logic      [4:0] phy_power_on,
   output logic      [4:0] phy_rx_unused_off,
   output logic            ed_monitor_on,
   output logic            link_pulse
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   spmc_state_t q;
   spmc_state_t d;
   spmc_mode_t  mode_now;
   logic [4:0]  en_now;
   logic        run;
   logic        core_on;

   assign mode_now = spmc_mode_t'(q.pmc[`SPMC_MODE_LSB+1:`SPMC_MODE_LSB]);
   assign en_now   = q.en_s[9:5];
   assign run      = (q.st == SPMC_ST_RUN);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0] rv;
      rv = 8'h00;
      d = q;
      d.pd_s = {q.pd_s[0], chip_power_down_input_n};
      d.en_s = {q.en_s[4:0], cable_energy};
      d.pulse = 1'b0;
      case (q.st)
         SPMC_ST_RUN: begin
            if (!q.pd_s[1]) begin
               d.st = SPMC_ST_PDN;
            end else if (mode_now == SPMC_SOFT_PD) begin
               // Access is a wake event only; its data is dropped
               if (reg_wr || reg_rd) begin
                  d.st       = SPMC_ST_IRST;
                  d.irst_cnt = `SPMC_IRST_CYC;
               end
            end else begin
               if (reg_wr) begin
                  if (reg_addr == `SPMC_ADDR_PMC) begin
                     d.pmc = reg_wdata;
                  end else if (reg_addr == `SPMC_ADDR_SIT) begin
                     d.sit = reg_wdata;
                  end
                  for (int p = 0; p < `SPMC_NUM_PORTS; p++) begin
                     if (reg_addr == 8'(`SPMC_ADDR_PC13_P1 + p * `SPMC_PORT_STRIDE)) begin
                        d.pc13[p] = reg_wdata;
                     end
                  end
               end
               if (reg_rd) begin
                  if (reg_addr == `SPMC_ADDR_PMC) begin
                     rv = q.pmc;
                  end else if (reg_addr == `SPMC_ADDR_SIT) begin
                     rv = q.sit;
                  end
                  for (int p = 0; p < `SPMC_NUM_PORTS; p++) begin
                     if (reg_addr == 8'(`SPMC_ADDR_PC13_P1 + p * `SPMC_PORT_STRIDE)) begin
                        rv = q.pc13[p];
                     end
                  end
                  d.rdata = rv;
               end
            end
         end
         SPMC_ST_PDN: begin
            if (q.pd_s[1]) begin
               d.st       = SPMC_ST_IRST;
               d.irst_cnt = `SPMC_IRST_CYC;
            end
         end
         SPMC_ST_IRST: begin
            if (!q.pd_s[1]) begin
               d.st = SPMC_ST_PDN;
            end else if (q.irst_cnt == 4'h0) begin
               d.st = SPMC_ST_RUN;
            end else begin
               d.irst_cnt = q.irst_cnt - 4'h1;
            end
         end
         default: begin
            d.st = SPMC_ST_RUN;
         end
      endcase
      // Energy detect idle timer and line pulse
      if (run && d.st == SPMC_ST_RUN && mode_now == SPMC_ENERGY) begin
         if (|en_now) begin
            d.tick_cnt = 17'h00000;
            d.idle_cnt = 9'h000;
            d.ed_low   = 1'b0;
         end else begin
            if (q.tick_cnt == 17'(SLEEP_UNIT_CYC - 1)) begin
               d.tick_cnt = 17'h00000;
               // Saturates so a long idle never wraps back awake
               if (q.idle_cnt != 9'h1ff) begin
                  d.idle_cnt = q.idle_cnt + 9'h001;
               end
            end else begin
               d.tick_cnt = q.tick_cnt + 17'h00001;
            end
            if (q.idle_cnt > {1'b0, q.sit}) begin
               d.ed_low = 1'b1;
            end
         end
         if (q.pulse_cnt == 27'(PULSE_PER_CYC - 1)) begin
            d.pulse_cnt = 27'h0000000;
         end else begin
            d.pulse_cnt = q.pulse_cnt + 27'h0000001;
         end
         d.pulse = (q.pulse_cnt < 27'(`SPMC_PULSE_W_CYC));
      end else begin
         d.tick_cnt  = 17'h00000;
         d.idle_cnt  = 9'h000;
         d.ed_low    = 1'b0;
         d.pulse_cnt = 27'h0000000;
      end
      // Internal reset returns every register to its default
      if (q.st == SPMC_ST_IRST || q.st == SPMC_ST_PDN) begin
         d.pmc   = `SPMC_PMC_RST;
         d.sit   = `SPMC_SIT_RST;
         d.rdata = 8'h00;
         for (int p = 0; p < `SPMC_NUM_PORTS; p++) begin
            d.pc13[p] = `SPMC_PC13_RST;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q       <= '0;
         q.st    <= SPMC_ST_RUN;
         q.pd_s  <= 2'h3;
         q.pmc   <= `SPMC_PMC_RST;
         q.sit   <= `SPMC_SIT_RST;
         q.pc13  <= {`SPMC_NUM_PORTS{`SPMC_PC13_RST}};
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Power controls
   // ---------------------------------------------------------------
   // Soft power down and the sleeping energy state gate the whole core
   assign core_on = run && (mode_now != SPMC_SOFT_PD)
                    && !(mode_now == SPMC_ENERGY && q.ed_low);

   assign chip_powered_down = (q.st == SPMC_ST_PDN);
   assign int_reset         = (q.st == SPMC_ST_IRST);
   assign pll_clk_en        = core_on;
   assign mac_power_on      = core_on;
   assign ed_monitor_on     = run && (mode_now == SPMC_ENERGY);
   assign link_pulse        = q.pulse;
   assign reg_rdata         = q.rdata;

   for (genvar gp = 0; gp < `SPMC_NUM_PORTS; gp++) begin : g_port
      assign phy_power_on[gp] = core_on && !q.pc13[gp][`SPMC_PORT_PD_BIT];
      assign phy_rx_unused_off[gp] = run && (mode_now == SPMC_SAVING)
                                     && an_enable[gp] && !en_now[gp];
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_hw_pdn_entry: assert property (
      run && !q.pd_s[1] |=> chip_powered_down && !pll_clk_en && phy_power_on == 5'h00)
      else $error("power-down pin did not power the chip down");

   a_release_reset: assert property (
      chip_powered_down && q.pd_s[1] |=> int_reset && mode_now == SPMC_NORMAL)
      else $error("no internal reset after power-down release");

   a_reset_default: assert property (
      $past(rst) |-> mode_now == SPMC_NORMAL && run)
      else $error("mode not normal after reset");

   a_normal_on: assert property (
      run && mode_now == SPMC_NORMAL |-> pll_clk_en && mac_power_on
      && phy_power_on == ~{q.pc13[4][3], q.pc13[3][3], q.pc13[2][3], q.pc13[1][3],
                          q.pc13[0][3]})
      else $error("normal mode power controls wrong");

   a_write_mode: assert property (
      run && q.pd_s[1] && mode_now == SPMC_NORMAL && reg_wr && reg_addr == `SPMC_ADDR_PMC
      |=> q.pmc == $past(reg_wdata))
      else $error("mode write not taken");

   a_sleep_entry: assert property (
      $rose(q.ed_low) |-> $past(q.idle_cnt) > {1'b0, q.sit} && mode_now == SPMC_ENERGY)
      else $error("sleep entered early");

   a_ed_low_state: assert property (
      run && mode_now == SPMC_ENERGY && q.ed_low |-> !pll_clk_en && !mac_power_on
      && phy_power_on == 5'h00 && ed_monitor_on)
      else $error("low power state left circuitry on");

   a_ed_wake: assert property (
      run && q.pd_s[1] && mode_now == SPMC_ENERGY && q.ed_low && |en_now |=> ##1 core_on)
      else $error("energy did not wake the chip");

   a_pulse_width: assert property (
      $rose(link_pulse) |-> ##11 (link_pulse || mode_now != SPMC_ENERGY) ##1 !link_pulse)
      else $error("line pulse width wrong");

   a_soft_pd_off: assert property (
      run && mode_now == SPMC_SOFT_PD |-> !pll_clk_en && !mac_power_on && phy_power_on == 5'h00)
      else $error("soft power down left power on");

   a_soft_wake: assert property (
      run && q.pd_s[1] && chip_power_down_input_n && mode_now == SPMC_SOFT_PD
      && (reg_wr || reg_rd) |=> int_reset ##1 q.pmc == `SPMC_PMC_RST)
      else $error("host access did not wake soft power down");

   a_saving_rx: assert property (
      run && mode_now == SPMC_SAVING |-> pll_clk_en && mac_power_on
      && phy_rx_unused_off == (an_enable & ~en_now))
      else $error("power saving receiver control wrong");

   a_mode_read: assert property (
      run && q.pd_s[1] && mode_now != SPMC_SOFT_PD && reg_rd && !reg_wr
      && reg_addr == `SPMC_ADDR_PMC
      |=> reg_rdata == $past(q.pmc))
      else $error("mode read mismatch");

   a_pdn_all_off: assert property (
      chip_powered_down |-> !mac_power_on && !ed_monitor_on && !link_pulse && !int_reset)
      else $error("power-down left logic active");

   a_irst_defaults: assert property (
      int_reset || chip_powered_down |=> mode_now == SPMC_NORMAL
      && q.sit == `SPMC_SIT_RST && reg_rdata == 8'h00)
      else $error("internal reset kept register contents");

   a_irst_start: assert property (
      $rose(int_reset) |-> q.irst_cnt == `SPMC_IRST_CYC)
      else $error("internal reset started with wrong length");

   a_irst_end: assert property (
      int_reset && q.irst_cnt == 4'h0 && q.pd_s[1] |=> run && !int_reset)
      else $error("internal reset did not end");

   a_soft_refuse: assert property (
      run && q.pd_s[1] && mode_now == SPMC_SOFT_PD && reg_wr |=> q.pmc == $past(q.pmc))
      else $error("write stored during soft power down");

   a_pulse_in_ed: assert property (
      link_pulse |-> $past(run) && $past(mode_now) == SPMC_ENERGY)
      else $error("line pulse outside energy detect");

   a_ed_no_early: assert property (
      !q.ed_low && q.idle_cnt <= {1'b0, q.sit} |=> !q.ed_low)
      else $error("sleep entered before go-sleep time");

   a_saving_tx: assert property (
      run && mode_now == SPMC_SAVING |-> phy_power_on == ~{q.pc13[4][3], q.pc13[3][3],
      q.pc13[2][3], q.pc13[1][3], q.pc13[0][3]})
      else $error("power saving turned a transmitter off");

   a_idle_restart: assert property (
      run && q.pd_s[1] && mode_now == SPMC_ENERGY && |en_now |=> q.idle_cnt == 9'h000)
      else $error("go-sleep count not restarted by energy");

endmodule : spmc_top

//--- hdl/spmc_regs.svh
// Register map, field positions, reset values and timing counts of the power mode controller
`ifndef SPMC_REGS_SVH
`define SPMC_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SPMC_ADDR_PMC        8'h0e
`define SPMC_ADDR_SIT        8'h0f
`define SPMC_ADDR_PC13_P1    8'h1d
`define SPMC_PORT_STRIDE     8'h10

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define SPMC_MODE_LSB        3
`define SPMC_PORT_PD_BIT     3
`define SPMC_NUM_PORTS       5
`define SPMC_PMC_RST         8'h00
`define SPMC_SIT_RST         8'h32
`define SPMC_PC13_RST        8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SPMC_CLK_NS          10
`define SPMC_PULSE_W_NS      120
`define SPMC_PULSE_W_CYC     ((`SPMC_PULSE_W_NS + `SPMC_CLK_NS - 1) / `SPMC_CLK_NS)
`define SPMC_PULSE_PER_NS    1000000000
`define SPMC_PULSE_PER_CYC   (`SPMC_PULSE_PER_NS / `SPMC_CLK_NS)
`define SPMC_SLEEP_UNIT_NS   1000000
`define SPMC_SLEEP_UNIT_CYC  (`SPMC_SLEEP_UNIT_NS / `SPMC_CLK_NS)
`define SPMC_IRST_CYC        4'hf

`endif

//--- hdl/spmc_pkg.sv
// Types of the power mode controller
package spmc_pkg;

   // ---------------------------------------------------------------
   // Modes and sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SPMC_NORMAL  = 2'h0,
      SPMC_ENERGY  = 2'h1,
      SPMC_SOFT_PD = 2'h2,
      SPMC_SAVING  = 2'h3
   } spmc_mode_t;

   typedef enum logic [1:0] {
      SPMC_ST_RUN  = 2'h0,
      SPMC_ST_PDN  = 2'h1,
      SPMC_ST_IRST = 2'h3
   } spmc_seq_t;

   // ---------------------------------------------------------------
   // Whole state of the controller
   // ---------------------------------------------------------------
   typedef struct packed {
      spmc_seq_t       st;
      logic [1:0]      pd_s;
      logic [9:0]      en_s;
      logic [7:0]      pmc;
      logic [7:0]      sit;
      logic [4:0][7:0] pc13;
      logic [7:0]      rdata;
      logic [3:0]      irst_cnt;
      logic [16:0]     tick_cnt;
      logic [8:0]      idle_cnt;
      logic            ed_low;
      logic [26:0]     pulse_cnt;
      logic            pulse;
   } spmc_state_t;

endpackage : spmc_pkg

//--- bench/spmc_host_model.sv
// Host processor model driving the register port of the controller
`timescale 1ns/1ns

module spmc_host_model (
   input  wire logic       mclk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // Idle lines show the inverse, so a stale address never looks valid
   task automatic release_bus();
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask : release_bus

   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge mclk);
      release_bus();
   endtask : write

   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge mclk);
      release_bus();
      @(negedge mclk);
      d = reg_rdata;
   endtask : read
endmodule : spmc_host_model

//--- bench/testbench.sv
// Self-checking bench of the power mode controller
`timescale 1ns/1ns

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module testbench;
   import spmc_pkg::*;
   localparam int unsigned PER  = 64;
   localparam int unsigned UNIT = 4;
   logic       mclk, rst, chip_power_down_input_n, reg_wr, reg_rd;
   logic [4:0] cable_energy, an_enable, phy_power_on, phy_rx_unused_off;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       chip_powered_down, int_reset, pll_clk_en, mac_power_on;
   logic       ed_monitor_on, link_pulse;
   int         fail_count, samples_checked, cycles, n;

   spmc_top #(.PULSE_PER_CYC(PER), .SLEEP_UNIT_CYC(UNIT)) spmc_top_inst (
      .mclk(mclk), .rst(rst), .chip_power_down_input_n(chip_power_down_input_n),
      .cable_energy(cable_energy), .an_enable(an_enable), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .chip_powered_down(chip_powered_down),
      .int_reset(int_reset), .pll_clk_en(pll_clk_en), .mac_power_on(mac_power_on),
      .phy_power_on(phy_power_on), .phy_rx_unused_off(phy_rx_unused_off),
      .ed_monitor_on(ed_monitor_on), .link_pulse(link_pulse));

   spmc_host_model spmc_host_model_inst (
      .mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      spmc_host_model_inst.write(a, d);
      @(negedge mclk);
   endtask : wr

   task automatic rd_chk(input string s, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      spmc_host_model_inst.read(a, v);
      `CHK(s, e, v)
   endtask : rd_chk

   // Bounded wait, so a stuck output ends as a mismatch, not a hang
   task automatic wait_for(ref logic s, input logic v, input int lim);
      for (n = 0; n < lim && s !== v; n++) @(negedge mclk);
   endtask : wait_for

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_defaults();
      rd_chk("mode", 8'h0e, 8'h00);
      rd_chk("sleep", 8'h0f, 8'h32);
      rd_chk("ctl13", 8'h1d, 8'h00);
      rd_chk("unmapped", 8'h01, 8'h00);
      `CHK("on", 7'h7f, {pll_clk_en, mac_power_on, phy_power_on})
   endtask : t_defaults

   task automatic t_port_pd();
      for (int p = 0; p < 5; p++) begin
         wr(8'h1d + 8'(p << 4), 8'h08);
         `CHK("phy", ~(5'h01 << p), phy_power_on)
         wr(8'h1d + 8'(p << 4), 8'h00);
      end
   endtask : t_port_pd

   task automatic t_modes();
      wr(8'h0e, 8'h08);
      `CHK("ed", 1'b1, ed_monitor_on)
      rd_chk("mode", 8'h0e, 8'h08);
      wr(8'h0e, 8'h00);
      `CHK("ed", 1'b0, ed_monitor_on)
      wr(8'h0e, 8'h18);
      `CHK("rx", 5'h1f, phy_rx_unused_off)
      `CHK("on", 7'h7f, {pll_clk_en, mac_power_on, phy_power_on})
      an_enable    = 5'h0f;
      cable_energy = 5'h03;
      repeat (3) @(negedge mclk);
      `CHK("rx", 5'h0c, phy_rx_unused_off)
      an_enable    = 5'h1f;
      cable_energy = 5'h00;
      repeat (3) @(negedge mclk);
      rd_chk("mode", 8'h0e, 8'h18);
      wr(8'h0e, 8'h00);
      `CHK("rx", 5'h00, phy_rx_unused_off)
   endtask : t_modes

   task automatic t_energy();
      int hi;
      wr(8'h0f, 8'h02);
      wr(8'h0e, 8'h08);
      repeat (6) @(negedge mclk);
      cable_energy = 5'h01;
      repeat (3) @(negedge mclk);
      cable_energy = 5'h00;
      wait_for(pll_clk_en, 1'b0, 60);
      `CHK("late", 1'b1, n >= 10)
      `CHK("low", 8'h01, {pll_clk_en, mac_power_on, phy_power_on, ed_monitor_on})
      hi = 0;
      repeat (2 * PER) begin
         @(negedge mclk);
         hi += int'(link_pulse === 1'b1);
      end
      `CHK("pulse", 24, hi)
      cable_energy = 5'h04;
      wait_for(pll_clk_en, 1'b1, 8);
      `CHK("wake", 2'h3, {pll_clk_en, mac_power_on})
      wr(8'h0e, 8'h00);
      cable_energy = 5'h00;
   endtask : t_energy

   task automatic t_soft_pd();
      logic [7:0] v;
      wr(8'h0f, 8'h05);
      wr(8'h0e, 8'h10);
      `CHK("off", 7'h00, {pll_clk_en, mac_power_on, phy_power_on})
      spmc_host_model_inst.read(8'h0e, v);
      wait_for(int_reset, 1'b1, 4);
      `CHK("irst", 1'b1, int_reset)
      wait_for(int_reset, 1'b0, 20);
      rd_chk("mode", 8'h0e, 8'h00);
      rd_chk("sleep", 8'h0f, 8'h32);
   endtask : t_soft_pd

   task automatic t_pin();
      wr(8'h0f, 8'h07);
      chip_power_down_input_n = 1'b0;
      wait_for(chip_powered_down, 1'b1, 5);
      `CHK("pd", 2'h2, {chip_powered_down, pll_clk_en})
      repeat (10) @(negedge mclk);
      chip_power_down_input_n = 1'b1;
      wait_for(int_reset, 1'b1, 6);
      `CHK("irst", 1'b1, int_reset)
      wait_for(int_reset, 1'b0, 20);
      `CHK("pd", 1'b0, chip_powered_down)
      rd_chk("sleep", 8'h0f, 8'h32);
   endtask : t_pin

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Whole run is under 2000 cycles; the ceiling leaves ample margin
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end

   initial begin
      fail_count = 0;
      samples_checked = 0;
      cycles = 0;
      rst = 1'b1;
      chip_power_down_input_n = 1'b1;
      cable_energy = 5'h00;
      an_enable = 5'h1f;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      t_defaults();
      t_port_pd();
      t_modes();
      t_energy();
      t_soft_pd();
      t_pin();
      summarize();
   end
endmodule : testbench
